// [core/ncai_pkg.sv]
// Shared constants, types and command decoding for the NAND host controller.
package ncai_pkg;

	// ==========================================================
	// Clock and bus timing
	localparam int CLK_MHZ = 40;
	localparam int T_WP_NS = 25;
	localparam int T_WH_NS = 25;
	localparam int T_SETUP_NS = 25;
	localparam int T_REA_NS = 25;
	localparam int T_WB_NS = 100;
	localparam int SYNC_STAGES = 2;

	function automatic int min_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction

	localparam logic [3:0] WP_CYC = 4'(min_cyc(T_WP_NS));
	localparam logic [3:0] WH_CYC = 4'(min_cyc(T_WH_NS));
	localparam logic [3:0] SETUP_CYC = 4'(min_cyc(T_SETUP_NS));
	localparam logic [3:0] RD_LOW_CYC = 4'(min_cyc(T_REA_NS) + SYNC_STAGES);
	localparam logic [3:0] WB_CYC = 4'(min_cyc(T_WB_NS));
	localparam logic [3:0] CNT_ONE = 4'h1;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_READ_CB_GO = 8'h35;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PLANE1_END = 8'h11;
	localparam logic [7:0] CMD_PLANE2 = 8'h81;
	localparam logic [7:0] CMD_PROG_CB = 8'h85;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_RAND_OUT = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_DIE0_STATUS = 8'hf1;
	localparam logic [7:0] CMD_DIE1_STATUS = 8'hf2;
	localparam logic [7:0] CMD_NONE = 8'h00;

	// ==========================================================
	// Geometry and address layout
	localparam int ADDR_W = 31;
	localparam int COL_W = 12;
	localparam int LEN_W = 12;
	localparam logic [11:0] PAGE_BYTES = 12'h840;
	localparam logic [11:0] COL_LAST = 12'h83f;
	localparam logic [11:0] SPARE_FIRST = 12'h800;
	localparam int PLANES = 4;
	localparam int BLOCKS_PER_PLANE = 2048;
	localparam int BLOCKS = 8192;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int CELLS_PER_STRING = 32;
	localparam int PAGE_LSB = 12;
	localparam int PAGE_MSB = 17;
	localparam int PLANE_BIT = 18;
	localparam int GROUP_BIT = 19;
	localparam logic [2:0] A_COL0 = 3'h0;
	localparam logic [2:0] A_ID_END = 3'h1;
	localparam logic [2:0] A_ROW0 = 3'h2;
	localparam logic [2:0] A_END = 3'h5;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_READ_CB = 4'h1, OP_PROG = 4'h2, OP_PROG_CB = 4'h3,
		OP_PROG_P1 = 4'h4, OP_PROG_P2 = 4'h5, OP_ERASE = 4'h6, OP_ERASE_P1 = 4'h7,
		OP_ID = 4'h8, OP_RESET = 4'h9, OP_STATUS = 4'ha, OP_DIE_STATUS = 4'hb,
		OP_RAND_OUT = 4'hc, OP_RAND_IN = 4'hd
	} ncai_op_e;

	typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_DWR = 2'h2, K_DRD = 2'h3} ncai_kind_e;
	typedef enum logic [1:0] {D_NONE = 2'h0, D_WR = 2'h1, D_RD = 2'h2} ncai_dir_e;

	typedef struct packed {
		logic legal;
		logic [7:0] cmd1;
		logic [7:0] cmd2;
		logic has2;
		logic [2:0] afirst;
		logic [2:0] alast;
		ncai_dir_e dir;
		logic waitrb;
	} ncai_opinfo_s;

	// Undefined operation codes decode as illegal so they never reach the pins.
	function automatic ncai_opinfo_s op_info(input logic [3:0] op);
		ncai_opinfo_s oi;
		oi = '{1'b0, CMD_NONE, CMD_NONE, 1'b0, A_COL0, A_COL0, D_NONE, 1'b0};
		case (op)
			OP_READ: oi = '{1'b1, CMD_READ, CMD_READ_GO, 1'b1, A_COL0, A_END, D_RD, 1'b1};
			OP_READ_CB: oi = '{1'b1, CMD_READ, CMD_READ_CB_GO, 1'b1, A_COL0, A_END, D_NONE, 1'b1};
			OP_PROG: oi = '{1'b1, CMD_PROG, CMD_PROG_GO, 1'b1, A_COL0, A_END, D_WR, 1'b1};
			OP_PROG_CB: oi = '{1'b1, CMD_PROG_CB, CMD_PROG_GO, 1'b1, A_COL0, A_END, D_NONE, 1'b1};
			OP_PROG_P1: oi = '{1'b1, CMD_PROG, CMD_PLANE1_END, 1'b1, A_COL0, A_END, D_WR, 1'b1};
			OP_PROG_P2: oi = '{1'b1, CMD_PLANE2, CMD_PROG_GO, 1'b1, A_COL0, A_END, D_WR, 1'b1};
			OP_ERASE: oi = '{1'b1, CMD_ERASE, CMD_ERASE_GO, 1'b1, A_ROW0, A_END, D_NONE, 1'b1};
			OP_ERASE_P1: oi = '{1'b1, CMD_ERASE, CMD_NONE, 1'b0, A_ROW0, A_END, D_NONE, 1'b0};
			OP_ID: oi = '{1'b1, CMD_READ_ID, CMD_NONE, 1'b0, A_COL0, A_ID_END, D_RD, 1'b0};
			OP_RESET: oi = '{1'b1, CMD_RESET, CMD_NONE, 1'b0, A_COL0, A_COL0, D_NONE, 1'b1};
			OP_STATUS: oi = '{1'b1, CMD_STATUS, CMD_NONE, 1'b0, A_COL0, A_COL0, D_RD, 1'b0};
			OP_DIE_STATUS: oi = '{1'b1, CMD_DIE0_STATUS, CMD_NONE, 1'b0, A_COL0, A_COL0, D_RD, 1'b0};
			OP_RAND_OUT: oi = '{1'b1, CMD_RAND_OUT, CMD_RAND_OUT_GO, 1'b1, A_COL0, A_ROW0, D_RD, 1'b0};
			OP_RAND_IN: oi = '{1'b1, CMD_PROG_CB, CMD_NONE, 1'b0, A_COL0, A_ROW0, D_WR, 1'b0};
			default: oi.legal = 1'b0;
		endcase
		return oi;
	endfunction

endpackage

// [core/ncai_cyc_if.sv]
// Handshake between the operation sequencer and the single bus cycle engine.
`timescale 1ns/1ps
interface ncai_cyc_if;
	import ncai_pkg::*;
	logic start;
	ncai_kind_e kind;
	logic [7:0] wbyte;
	logic done;
	logic [7:0] rbyte;
	modport seq (output start, output kind, output wbyte, input done, input rbyte);
	modport eng (input start, input kind, input wbyte, output done, output rbyte);
endinterface

// [core/ncai_sync.sv]
// Two-stage synchroniser for the pin inputs.
`timescale 1ns/1ps
module ncai_sync import ncai_pkg::*; #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ncai_sync_s;

	ncai_sync_s r_reg;
	ncai_sync_s r_next;

	// The first stage feeds only the second stage.
	always_comb begin
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;
endmodule

// [core/ncai_cycle.sv]
// Engine for one strobed bus cycle: command, address, data write or data read.
`timescale 1ns/1ps
module ncai_cycle import ncai_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	ncai_cyc_if.eng cyc,
	input wire logic [7:0] io_sync,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n
);
	typedef enum logic [3:0] {
		E_IDLE = 4'b0001, E_SETUP = 4'b0010, E_LOW = 4'b0100, E_HIGH = 4'b1000
	} ncai_eng_e;

	typedef struct packed {
		ncai_eng_e st;
		logic [3:0] cnt;
		logic rd;
		logic [7:0] io_out;
		logic io_oe;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic [7:0] rbyte;
		logic done;
	} ncai_eng_s;

	localparam ncai_eng_s ENG_RESET = '{E_IDLE, 4'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0,
		1'b1, 1'b1, 8'h00, 1'b0};

	ncai_eng_s r_reg;
	ncai_eng_s r_next;

	// ==========================================================
	// Cycle sequencing
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		unique case (r_reg.st)
			E_IDLE: begin
				if (cyc.start) begin
					r_next.rd = (cyc.kind == K_DRD);
					r_next.io_out = cyc.wbyte;
					r_next.io_oe = (cyc.kind != K_DRD);
					r_next.cle = (cyc.kind == K_CMD);
					r_next.ale = (cyc.kind == K_ADDR);
					r_next.cnt = SETUP_CYC - CNT_ONE;
					r_next.st = E_SETUP;
				end
			end
			E_SETUP: begin
				if (r_reg.cnt == '0) begin
					r_next.we_n = r_reg.rd;
					r_next.re_n = !r_reg.rd;
					r_next.cnt = (r_reg.rd ? RD_LOW_CYC : WP_CYC) - CNT_ONE;
					r_next.st = E_LOW;
				end else begin
					r_next.cnt = r_reg.cnt - CNT_ONE;
				end
			end
			E_LOW: begin
				if (r_reg.cnt == '0) begin
					// The low phase already covers access time plus synchroniser delay.
					if (r_reg.rd) begin
						r_next.rbyte = io_sync;
					end
					r_next.we_n = 1'b1;
					r_next.re_n = 1'b1;
					r_next.cnt = WH_CYC - CNT_ONE;
					r_next.st = E_HIGH;
				end else begin
					r_next.cnt = r_reg.cnt - CNT_ONE;
				end
			end
			E_HIGH: begin
				if (r_reg.cnt == '0) begin
					r_next.cle = 1'b0;
					r_next.ale = 1'b0;
					r_next.io_oe = 1'b0;
					r_next.done = 1'b1;
					r_next.st = E_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - CNT_ONE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= ENG_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign io_out = r_reg.io_out;
	assign io_oe = r_reg.io_oe;
	assign cle = r_reg.cle;
	assign ale = r_reg.ale;
	assign we_n = r_reg.we_n;
	assign read_strobe_n = r_reg.re_n;
	assign cyc.done = r_reg.done;
	assign cyc.rbyte = r_reg.rbyte;
endmodule

// [core/ncai_host.sv]
// Host controller that drives a two-die multiplexed NAND flash through its pins.
// Notes on behaviour
// - Bytes go out on eight I/O lines, write strobe low, select low.
// - Command bytes raise the command latch, address bytes the address latch.
// - Read, program and erase send setup byte, later execution byte.
// - Full 31-bit address: two column cycles, then three row cycles.
// - Read is 00h, address, 30h; program is 80h, address, data, 10h.
// - Erase is 60h with only three row cycles, then D0h.
// - Random output 05h column E0h; random input 85h column; same page.
// - Between 11h and 81h only 70h, F1h, F2h or FFh are allowed.
// - Per-die status F1h/F2h only during interleaved work across both dies.
// - Each die has its own select; one die may work while other addressed.
// - Never send a command code outside the defined set.
// - Two-plane work pairs plane 0 with 1 or 2 with 3 only.
`timescale 1ns/1ps
module ncai_host import ncai_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [3:0] req_op,
	input wire logic req_die,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [LEN_W-1:0] req_len,
	input wire logic req_detach,
	output logic resp_done,
	output logic resp_err,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic die0_select_n,
	output logic die1_select_n,
	output logic write_protect_n,
	input wire logic die0_ready,
	input wire logic die1_ready
);
	// ==========================================================
	// State
	typedef enum logic [7:0] {
		S_IDLE = 8'b0000_0001, S_CMD1 = 8'b0000_0010, S_ADDR = 8'b0000_0100,
		S_DATA = 8'b0000_1000, S_CMD2 = 8'b0001_0000, S_WB = 8'b0010_0000,
		S_RDY = 8'b0100_0000, S_END = 8'b1000_0000
	} ncai_st_e;

	typedef struct packed {
		ncai_st_e st;
		logic [3:0] op;
		logic die;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] left;
		logic [2:0] aidx;
		logic [3:0] cnt;
		logic detach;
		logic pend;
		logic start;
		ncai_kind_e kind;
		logic [7:0] wbyte;
		logic plane_prog;
		logic plane_erase;
		logic [1:0] plane_first;
		logic req_ready;
		logic resp_done;
		logic resp_err;
		logic wr_ready;
		logic [7:0] rd_data;
		logic rd_valid;
		logic ce0_n;
		logic ce1_n;
		logic wp_n;
	} ncai_host_s;

	localparam ncai_host_s HOST_RESET = '{S_IDLE, 4'h0, 1'b0, 31'h0, 12'h000, 3'h0, 4'h0,
		1'b0, 1'b0, 1'b0, K_CMD, 8'h00, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00,
		1'b0, 1'b1, 1'b1, 1'b1};

	ncai_host_s r_reg;
	ncai_host_s r_next;

	// ==========================================================
	// Pin synchronisers and bus cycle engine
	logic [7:0] io_sync;
	logic [1:0] rdy_sync;

	ncai_sync #(.W(10)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({die1_ready, die0_ready, io_in}),
		.q({rdy_sync, io_sync})
	);

	ncai_cyc_if cyc ();

	ncai_cycle u_cycle (
		.clk(clk),
		.rst(rst),
		.cyc(cyc.eng),
		.io_sync(io_sync),
		.io_out(io_out),
		.io_oe(io_oe),
		.cle(cle),
		.ale(ale),
		.we_n(we_n),
		.read_strobe_n(read_strobe_n)
	);

	assign cyc.start = r_reg.start;
	assign cyc.kind = r_reg.kind;
	assign cyc.wbyte = r_reg.wbyte;

	// Column bytes first, then row bytes; unused high bits are sent low.
	function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a, input logic [2:0] i);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			3'h0: b = a[7:0];
			3'h1: b = {4'h0, a[11:8]};
			3'h2: b = a[19:12];
			3'h3: b = a[27:20];
			3'h4: b = {5'h0, a[30:28]};
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// ==========================================================
	// Request screening
	ncai_opinfo_s info_req;
	ncai_opinfo_s info_cur;
	logic die_busy;
	logic other_busy;
	logic is_status;
	logic is_reset;
	logic follows;
	logic pair_bad;
	logic refuse;

	assign info_req = op_info(req_op);
	assign info_cur = op_info(r_reg.op);
	assign die_busy = req_die ? !rdy_sync[1] : !rdy_sync[0];
	assign other_busy = req_die ? !rdy_sync[0] : !rdy_sync[1];
	assign is_status = (req_op == OP_STATUS) || (req_op == OP_DIE_STATUS);
	assign is_reset = (req_op == OP_RESET);
	assign follows = (r_reg.plane_prog && req_op == OP_PROG_P2) ||
		(r_reg.plane_erase && req_op == OP_ERASE);
	// Second plane must sit in the same pair as the first and be its partner.
	assign pair_bad = (req_addr[GROUP_BIT] != r_reg.plane_first[1]) ||
		(req_addr[PLANE_BIT] == r_reg.plane_first[0]);

	always_comb begin
		refuse = !info_req.legal;
		if (die_busy && !is_status && !is_reset) begin
			refuse = 1'b1;
		end
		if (req_op == OP_DIE_STATUS && !other_busy) begin
			refuse = 1'b1;
		end
		if ((r_reg.plane_prog || r_reg.plane_erase) && !is_status && !is_reset && !follows) begin
			refuse = 1'b1;
		end
		if (follows && pair_bad) begin
			refuse = 1'b1;
		end
		if (req_op == OP_PROG_P2 && !r_reg.plane_prog) begin
			refuse = 1'b1;
		end
		if (info_req.afirst == A_COL0 && info_req.alast != A_COL0 &&
			req_op != OP_ID && req_addr[COL_W-1:0] > COL_LAST) begin
			refuse = 1'b1;
		end
		if (info_req.dir != D_NONE && (req_len == '0 || req_len > PAGE_BYTES)) begin
			refuse = 1'b1;
		end
	end

	// ==========================================================
	// Operation sequencer
	always_comb begin
		r_next = r_reg;
		r_next.start = 1'b0;
		r_next.resp_done = 1'b0;
		r_next.rd_valid = 1'b0;
		r_next.wr_ready = 1'b0;
		unique case (r_reg.st)
			S_IDLE: begin
				r_next.req_ready = 1'b1;
				if (req_valid && r_reg.req_ready) begin
					r_next.req_ready = 1'b0;
					if (refuse) begin
						r_next.resp_done = 1'b1;
						r_next.resp_err = 1'b1;
					end else begin
						r_next.resp_err = 1'b0;
						r_next.op = req_op;
						r_next.die = req_die;
						r_next.addr = req_addr;
						if (req_op == OP_ID) begin
							r_next.addr = '0;
						end
						if (req_op == OP_ERASE || req_op == OP_ERASE_P1) begin
							r_next.addr[PAGE_MSB:PAGE_LSB] = '0;
						end
						r_next.left = (info_req.dir == D_NONE) ? '0 : req_len;
						r_next.aidx = info_req.afirst;
						r_next.detach = req_detach && info_req.dir != D_RD;
						if (is_reset || follows) begin
							r_next.plane_prog = 1'b0;
							r_next.plane_erase = 1'b0;
						end
						if (req_op == OP_PROG_P1 || req_op == OP_ERASE_P1) begin
							r_next.plane_prog = (req_op == OP_PROG_P1);
							r_next.plane_erase = (req_op == OP_ERASE_P1);
							r_next.plane_first = req_addr[GROUP_BIT:PLANE_BIT];
						end
						r_next.ce0_n = req_die;
						r_next.ce1_n = !req_die;
						r_next.st = S_CMD1;
					end
				end
			end
			S_CMD1: begin
				if (!r_reg.pend) begin
					r_next.start = 1'b1;
					r_next.pend = 1'b1;
					r_next.kind = K_CMD;
					r_next.wbyte = info_cur.cmd1;
					if (r_reg.op == OP_DIE_STATUS && r_reg.die) begin
						r_next.wbyte = CMD_DIE1_STATUS;
					end
				end else if (cyc.done) begin
					r_next.pend = 1'b0;
					r_next.cnt = WB_CYC - CNT_ONE;
					if (info_cur.afirst != info_cur.alast) begin
						r_next.st = S_ADDR;
					end else begin
						r_next.st = S_WB;
					end
				end
			end
			S_ADDR: begin
				if (!r_reg.pend) begin
					r_next.start = 1'b1;
					r_next.pend = 1'b1;
					r_next.kind = K_ADDR;
					r_next.wbyte = addr_byte(r_reg.addr, r_reg.aidx);
				end else if (cyc.done) begin
					r_next.pend = 1'b0;
					r_next.aidx = r_reg.aidx + 3'h1;
					r_next.cnt = WB_CYC - CNT_ONE;
					// Exactly the cycles the operation needs; erase stops after rows.
					if (r_reg.aidx + 3'h1 == info_cur.alast) begin
						if (info_cur.dir == D_WR) begin
							r_next.st = S_DATA;
						end else if (info_cur.has2) begin
							r_next.st = S_CMD2;
						end else begin
							r_next.st = S_WB;
						end
					end
				end
			end
			S_DATA: begin
				if (info_cur.dir == D_WR) begin
					if (!r_reg.pend) begin
						r_next.wr_ready = !(wr_valid && r_reg.wr_ready);
						if (wr_valid && r_reg.wr_ready) begin
							r_next.start = 1'b1;
							r_next.pend = 1'b1;
							r_next.kind = K_DWR;
							r_next.wbyte = wr_data;
						end
					end else if (cyc.done) begin
						r_next.pend = 1'b0;
						r_next.left = r_reg.left - 12'h001;
						if (r_reg.left == 12'h001) begin
							r_next.st = info_cur.has2 ? S_CMD2 : S_END;
						end
					end
				end else begin
					if (!r_reg.pend) begin
						r_next.start = 1'b1;
						r_next.pend = 1'b1;
						r_next.kind = K_DRD;
					end else if (cyc.done) begin
						r_next.pend = 1'b0;
						r_next.rd_data = cyc.rbyte;
						r_next.rd_valid = 1'b1;
						r_next.left = r_reg.left - 12'h001;
						if (r_reg.left == 12'h001) begin
							r_next.st = S_END;
						end
					end
				end
			end
			S_CMD2: begin
				if (!r_reg.pend) begin
					r_next.start = 1'b1;
					r_next.pend = 1'b1;
					r_next.kind = K_CMD;
					r_next.wbyte = info_cur.cmd2;
				end else if (cyc.done) begin
					r_next.pend = 1'b0;
					r_next.cnt = WB_CYC - CNT_ONE;
					r_next.st = S_WB;
				end
			end
			S_WB: begin
				// Ready-busy is not valid until the busy delay has passed.
				if (r_reg.cnt != '0) begin
					r_next.cnt = r_reg.cnt - CNT_ONE;
				end else if (info_cur.waitrb && !r_reg.detach) begin
					r_next.st = S_RDY;
				end else if (info_cur.dir == D_RD) begin
					r_next.st = S_DATA;
				end else begin
					r_next.st = S_END;
				end
			end
			S_RDY: begin
				if (r_reg.die ? rdy_sync[1] : rdy_sync[0]) begin
					r_next.st = (info_cur.dir == D_RD) ? S_DATA : S_END;
				end
			end
			S_END: begin
				// Deselecting is safe: a started operation runs on inside the die.
				r_next.ce0_n = 1'b1;
				r_next.ce1_n = 1'b1;
				r_next.resp_done = 1'b1;
				r_next.resp_err = 1'b0;
				r_next.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= HOST_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign req_ready = r_reg.req_ready;
	assign resp_done = r_reg.resp_done;
	assign resp_err = r_reg.resp_err;
	assign wr_ready = r_reg.wr_ready;
	assign rd_data = r_reg.rd_data;
	assign rd_valid = r_reg.rd_valid;
	assign die0_select_n = r_reg.ce0_n;
	assign die1_select_n = r_reg.ce1_n;
	assign write_protect_n = r_reg.wp_n;
endmodule

// [test/ncai_host_checker.sv]
// Pin and reply checks for the NAND host controller.
`timescale 1ns/1ps
module ncai_host_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic resp_done,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic die0_select_n,
	input wire logic die1_select_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Strobe shapes, latch exclusion, die selects and bus direction
	sequence s_rd_low;
		!read_strobe_n [*3] ##1 read_strobe_n;
	endsequence
	property p_excl; !(cle && ale); endproperty
	property p_sel; !we_n |-> die0_select_n != die1_select_n; endproperty
	property p_one; !(!die0_select_n && !die1_select_n); endproperty
	property p_we; $fell(we_n) |=> we_n; endproperty
	property p_setup; $fell(we_n) |-> io_oe && $stable(io_out) && $stable(cle) && $stable(ale);
	endproperty
	property p_rd; $fell(read_strobe_n) |-> s_rd_low; endproperty
	property p_float; !read_strobe_n |-> !io_oe && we_n; endproperty
	property p_free; resp_done |-> die0_select_n && die1_select_n; endproperty
	a_excl: assert property (p_excl) else $error("both latches high");
	a_sel: assert property (p_sel) else $error("write strobe without one select");
	a_one: assert property (p_one) else $error("two dies selected");
	a_we: assert property (p_we) else $error("write strobe low too long");
	a_setup: assert property (p_setup) else $error("byte not set up");
	a_rd: assert property (p_rd) else $error("read strobe shape wrong");
	a_float: assert property (p_float) else $error("bus driven during read");
	a_free: assert property (p_free) else $error("select held at end");
endmodule
bind ncai_host ncai_host_checker u_chk (.clk(clk), .rst(rst), .resp_done(resp_done),
	.io_out(io_out), .io_oe(io_oe), .cle(cle), .ale(ale), .we_n(we_n),
	.read_strobe_n(read_strobe_n), .die0_select_n(die0_select_n),
	.die1_select_n(die1_select_n));

// [test/ncai_flash_model.sv]
// Behavioural model of one NAND die seen from its pins.
`timescale 1ns/1ps
module ncai_flash_model #(
	parameter int BUSY_NS = 2000,
	parameter logic [7:0] ID0 = 8'h3c
) (
	input wire logic sel_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_q,
	output logic io_drv,
	output logic rdy
);
	// The identifier value ID0 is arbitrary.
	logic [9:0] lg [0:255];
	logic [7:0] pg [0:2111];
	logic [7:0] mode = 8'h00;
	int n = 0;
	int bad = 0;
	int col = 0;
	int na = 0;
	initial rdy = 1'b1;
	always @(posedge we_n) begin
		if (!sel_n) begin
			lg[n[7:0]] = {cle, ale, io_in};
			n++;
			if (cle) begin
				if (!rdy && !(io_in inside {8'hff, 8'h70, 8'hf1, 8'hf2})) bad++;
				if (io_in inside {8'h11, 8'h30, 8'h35, 8'h10, 8'hd0, 8'hff}) rdy = 1'b0;
				mode = io_in;
				na = 0;
			end else if (ale) begin
				if (na == 0) col = io_in;
				if (na == 1) col += 256 * io_in[3:0];
				na++;
			end else begin
				pg[col % 2112] = io_in;
				col++;
			end
		end
	end
	always @(negedge read_strobe_n) begin
		if (!sel_n) begin
			io_q = (mode inside {8'h70, 8'hf1, 8'hf2}) ? {1'b1, rdy, 6'h00} :
				mode == 8'h90 ? ID0 : pg[col % 2112];
			if (!(mode inside {8'h70, 8'hf1, 8'hf2, 8'h90})) col++;
		end
	end
	// Driving only while strobed keeps the shared lines free for the host.
	assign io_drv = !sel_n && !read_strobe_n;
	always @(negedge rdy) #(BUSY_NS) rdy = 1'b1;
endmodule

// [test/ncai_host_bench.sv]
// Self-checking bench for the NAND host controller.
`timescale 1ns/1ps
module ncai_host_bench;
	logic clk = 0, rst = 1, req_valid = 0, req_ready, req_detach = 0, resp_done, resp_err;
	logic [3:0] req_op = 0;
	logic [30:0] req_addr = 0;
	logic [11:0] req_len = 0;
	logic [7:0] wr_data = 0, rd_data, io_out, q0, q1, wc = 0;
	logic wr_ready, rd_valid, io_oe, cle, ale, we_n, re_n, s0_n, s1_n, d0, r0, err;
	logic d1, r1, wp_n, die = 0;
	logic [7:0] rb [0:15];
	int rn = 0, b = 0, mismatches = 0, comparisons = 0;
	wire [7:0] io_in = d0 ? q0 : d1 ? q1 : io_oe ? io_out : {8{clk}} ^ 8'ha5;
	ncai_host u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_die(die), .req_addr(req_addr), .req_len(req_len),
		.req_detach(req_detach), .resp_done(resp_done), .resp_err(resp_err),
		.wr_data(wr_data), .wr_valid(1'b1), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cle(cle),
		.ale(ale), .we_n(we_n), .read_strobe_n(re_n), .die0_select_n(s0_n),
		.die1_select_n(s1_n), .write_protect_n(wp_n), .die0_ready(r0), .die1_ready(r1));
	ncai_flash_model u_m0 (.sel_n(s0_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(re_n), .io_in(io_in), .io_q(q0), .io_drv(d0), .rdy(r0));
	ncai_flash_model u_m1 (.sel_n(s1_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(re_n), .io_in(io_in), .io_q(q1), .io_drv(d1), .rdy(r1));
	initial forever #12.5 clk = ~clk;
	always @(negedge clk) wr_data <= 8'h40 + wc;
	always @(posedge clk) begin
		if (wr_ready === 1'b1) wc <= wc + 8'h01;
		if (rd_valid === 1'b1) begin
			rb[rn[3:0]] <= rd_data;
			rn <= rn + 1;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic req(input logic [3:0] op, input logic [30:0] a, input logic [11:0] len,
			input logic det);
		int k;
		k = 0;
		@(negedge clk);
		b = u_m0.n;
		rn = 0;
		req_op = op;
		req_addr = a;
		req_len = len;
		req_detach = det;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		while (resp_done !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 5000) mismatches++;
		err = resp_err;
	endtask
	// Each entry is three hex digits: 2 command, 1 address, 0 data, then the byte.
	task automatic seq(input int cnt, input logic [191:0] e);
		chk(u_m0.n - b, cnt);
		for (int i = 0; i < cnt; i++) chk(u_m0.lg[8'(b + i)], e[12 * (cnt - 1 - i) +: 10]);
	endtask
	task automatic t_prog_read;
		wc = 0;
		req(4'h2, 31'h5003, 12'h004, 0);
		seq(11, 192'h280_103_100_105_100_100_040_041_042_043_210);
		req(4'h0, 31'h5003, 12'h004, 0);
		seq(7, 192'h200_103_100_105_100_100_230);
		for (int i = 0; i < 4; i++) chk(rb[i], 8'h40 + i);
	endtask
	task automatic t_busy;
		req(4'h6, 31'h127c000, 12'h000, 1);
		seq(5, 192'h260_140_112_100_2d0);
		req(4'h0, 31'h5003, 12'h004, 0);
		chk(err, 1);
		seq(0, 0);
		req(4'ha, 0, 12'h001, 0);
		chk(rb[0], 8'h80);
		while (r0 !== 1'b1) @(negedge clk);
		repeat (3) @(negedge clk);
		req(4'ha, 0, 12'h001, 0);
		seq(1, 192'h270);
		chk(rb[0], 8'hc0);
	endtask
	task automatic t_copy_rand;
		req(4'h1, 31'h5003, 12'h000, 0);
		seq(7, 192'h200_103_100_105_100_100_235);
		req(4'h3, 31'h6000, 12'h000, 0);
		seq(7, 192'h285_100_100_106_100_100_210);
		req(4'hc, 31'h4, 12'h002, 0);
		seq(4, 192'h205_104_100_2e0);
		chk({rb[0], rb[1]}, 16'h4142);
		wc = 0;
		req(4'hd, 31'h7, 12'h001, 0);
		seq(4, 192'h285_107_100_040);
	endtask
	task automatic t_plane;
		wc = 0;
		req(4'h4, 0, 12'h001, 0);
		seq(8, 192'h280_100_100_100_100_100_040_211);
		req(4'ha, 0, 12'h001, 0);
		chk(err, 0);
		req(4'h5, 31'hc0000, 12'h001, 0);
		chk(err, 1);
		req(4'h5, 31'h40000, 12'h001, 0);
		seq(8, 192'h281_100_100_140_100_100_041_210);
	endtask
	task automatic t_plane_erase;
		req(4'h7, 31'h0, 12'h000, 0);
		seq(4, 192'h260_100_100_100);
		req(4'h0, 31'h0, 12'h001, 0);
		chk(err, 1);
		req(4'h6, 31'h40000, 12'h000, 0);
		seq(5, 192'h260_140_100_100_2d0);
	endtask
	task automatic t_die;
		die = 1;
		req(4'h6, 31'h0, 12'h000, 1);
		seq(0, 0);
		chk(u_m1.n, 5);
		chk(u_m1.lg[4], 10'h2d0);
		die = 0;
		req(4'hb, 0, 12'h001, 0);
		seq(1, 192'h2f1);
		chk(rb[0], 8'hc0);
		while (r1 !== 1'b1) @(negedge clk);
		repeat (3) @(negedge clk);
		req(4'hb, 0, 12'h001, 0);
		chk(err, 1);
	endtask
	task automatic t_misc;
		req(4'he, 0, 12'h001, 0);
		chk(err, 1);
		req(4'h8, 0, 12'h001, 0);
		seq(2, 192'h290_100);
		chk(rb[0], 8'h3c);
		req(4'h9, 0, 12'h000, 0);
		seq(1, 192'h2ff);
		chk(u_m0.bad, 0);
		chk(wp_n, 1);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_prog_read;
		t_busy;
		t_copy_rand;
		t_plane;
		t_plane_erase;
		t_misc;
		t_die;
		end_of_test;
	end
endmodule
